// [inc/dbsram_map.svh]
/*
 * Constants of the burst-of-two DDR SRAM data port: widths, depths, latency.
 * Assumes inclusion by bare name from any design or bench file.
 */
`ifndef DBSRAM_MAP_SVH
`define DBSRAM_MAP_SVH

// ============================================================
// Organisation
`define DBS_DATA_W 18
`define DBS_WIDE_DATA_W 36
`define DBS_BYTE_W 9
`define DBS_ADDR_W 8
`define DBS_BURST_LEN 2
`define DBS_FIFO_DEPTH 32
`define DBS_FIFO_PTR_W 5

// ============================================================
// Read pipeline
`define DBS_READ_LAT 2

`endif

// [inc/dbsram_pkg.sv]
/*
 * Types shared by the SRAM data port and its testbench.
 * Assumes dbsram_map.svh is on the include path.
 */
`include "dbsram_map.svh"

package dbsram_pkg;
	localparam int DBS_NBYTE = `DBS_DATA_W / `DBS_BYTE_W;
	typedef logic [`DBS_DATA_W-1:0] dbsram_word_t;
	typedef logic [`DBS_ADDR_W-1:0] dbsram_addr_t;
	typedef enum logic [1:0] {
		DBS_IDLE,
		DBS_WRITE,
		DBS_READ
	} dbsram_phase_e;
endpackage

// [src/dbsram_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides, honest full and empty.
 * Assumes one clock and a synchronous active-high reset.
 */
module dbsram_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32,
	parameter int PTR_W = 5
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W:0] wrPtr_r;
	logic [PTR_W:0] rdPtr_r;
	wire full = (wrPtr_r[PTR_W] != rdPtr_r[PTR_W]) &&
		(wrPtr_r[PTR_W-1:0] == rdPtr_r[PTR_W-1:0]);
	wire empty = wrPtr_r == rdPtr_r;
	wire doWr = inValid && !full;
	wire doRd = outReady && !empty;

	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_r[PTR_W-1:0]];

	// ============================================================
	// Storage and pointers
	always_ff @(posedge mclk) begin
		if (doWr) begin
			mem[wrPtr_r[PTR_W-1:0]] <= inData;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_r + (PTR_W+1)'(doWr);
			rdPtr_r <= rdPtr_r + (PTR_W+1)'(doRd);
		end
	end
endmodule // dbsram_fifo

// [src/dbsram_port.sv]
/*
 * Device-side data port of a two-word-burst DDR SRAM, modelled at mclk.
 * One mclk cycle is one data edge: kPhase high marks a positive-clock
 * rising edge, low marks the following negative-clock rising edge.
 * Assumes the controller keeps its own protocol obligations.
 */
`include "dbsram_map.svh"

// Overview of operation
// (RULE1) Write data sampled on both clock edges
// (RULE2) Read data driven while read active
// (RULE3) Read words launched on both edges
// (RULE4) Outputs released when no read
// (RULE5) Shared data bus, eighteen bits wide
// (RULE6) Load strobe sampled on positive edge only
// (RULE7) Controller gives address, direction with strobe
// (RULE8) Every access moves exactly two words
// (RULE9) Select high reads, low writes
// (RULE10) Byte selects gate nine-bit groups
// (RULE11) Valid flag marks valid read data
// (RULE12) Accesses start on positive edge only
// (RULE13) First word positive, second negative edge
module dbsram_port
	import dbsram_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic kPhase,
	input wire logic load_strobe_n,
	input wire logic readSel,
	input wire dbsram_addr_t addr,
	input wire logic [DBS_NBYTE-1:0] byte_write_select_n,
	input wire dbsram_word_t dataIn,
	output dbsram_word_t dataOut,
	output logic dataOe,
	output logic output_valid_flag,
	output logic echo_clock,
	output logic echo_clock_n,
	output logic wrLogValid,
	input wire logic wrLogReady,
	output dbsram_word_t wrLogData,
	output logic cmdStall
);
	localparam int DEPTH = 1 << `DBS_ADDR_W;
	dbsram_word_t mem [DEPTH];

	dbsram_phase_e phase_r;
	dbsram_phase_e phase_nxt;
	dbsram_addr_t baseAddr_r;
	dbsram_addr_t rdBase_r;
	logic [`DBS_FIFO_PTR_W:0] logLevel_r;
	logic [`DBS_FIFO_PTR_W:0] logLevel_nxt;
	logic [`DBS_READ_LAT-1:0] rdPipe_r;
	logic [`DBS_READ_LAT-1:0] rdPipe_nxt;
	dbsram_addr_t rdAddr_r [`DBS_READ_LAT];
	dbsram_word_t dataOut_r;
	logic oe_r;
	logic valid_r;
	logic echo_r;

	// ============================================================
	// Command decode
	logic fifoReady;
	// Two free slots, so beat two never meets a full log
	wire logRoom = logLevel_r <=
		(`DBS_FIFO_PTR_W+1)'(`DBS_FIFO_DEPTH - 2);
	// (RULE6) strobe only on positive edge
	// (RULE12) start only on positive edge
	wire loadHit = kPhase && !load_strobe_n;
	// (RULE9) high reads, low writes
	wire startRd = loadHit && readSel;
	wire startWr = loadHit && !readSel && logRoom;
	// (RULE13) beat index follows edge
	wire wrBeat = (phase_r == DBS_WRITE) && !kPhase;
	wire wrFirst = startWr;
	wire wrEdge = wrFirst || wrBeat;
	wire dbsram_addr_t wrAddr = wrFirst ? addr : (baseAddr_r | 8'h01);
	wire dbsram_addr_t burstBase = addr & 8'hFE;
	wire dbsram_addr_t wrAddrA = wrFirst ? burstBase : wrAddr;
	wire dbsram_word_t curWord = mem[wrAddrA];
	wire rdLaunch = rdPipe_r[`DBS_READ_LAT-1];
	wire dbsram_addr_t rdA = rdAddr_r[`DBS_READ_LAT-1];
	wire dbsram_addr_t rdWordAddr = kPhase ? rdA : (rdBase_r | 8'h01);
	// Launch only on a positive edge, word two rides the next edge
	wire rdActive = (rdLaunch && kPhase) || (oe_r && !kPhase);

	assign cmdStall = loadHit && !readSel && !logRoom;

	// ============================================================
	// Byte-gated merge of write data
	dbsram_word_t merged;
	genvar b;
	generate
		for (b = 0; b < DBS_NBYTE; b++) begin : g_byte
			// (RULE10) deasserted select keeps byte
			assign merged[b*`DBS_BYTE_W +: `DBS_BYTE_W] =
				byte_write_select_n[b] ?
				curWord[b*`DBS_BYTE_W +: `DBS_BYTE_W] :
				dataIn[b*`DBS_BYTE_W +: `DBS_BYTE_W];
		end
	endgenerate

	// ============================================================
	// Burst sequencing
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			DBS_IDLE: begin
				if (startWr) begin
					phase_nxt = DBS_WRITE;
				end
			end
			// (RULE8) exactly two beats per write
			DBS_WRITE: begin
				if (!kPhase) begin
					phase_nxt = DBS_IDLE;
				end
			end
			default: phase_nxt = DBS_IDLE;
		endcase
	end

	always_comb begin
		rdPipe_nxt = {rdPipe_r[`DBS_READ_LAT-2:0], 1'b0};
		if (kPhase) begin
			rdPipe_nxt = {rdPipe_r[`DBS_READ_LAT-2:0], startRd};
		end else begin
			rdPipe_nxt = rdPipe_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			phase_r <= DBS_IDLE;
			rdPipe_r <= '0;
			baseAddr_r <= '0;
		end else begin
			phase_r <= phase_nxt;
			rdPipe_r <= rdPipe_nxt;
			if (startWr) begin
				baseAddr_r <= burstBase;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (kPhase) begin
			rdAddr_r[0] <= addr & 8'hFE;
			rdAddr_r[1] <= rdAddr_r[0];
			// The launch edge shifts the pipe before word two
			rdBase_r <= rdA;
		end
	end

	// ============================================================
	// Array write and read
	// (RULE1) sample on both edges
	always_ff @(posedge mclk) begin
		if (wrEdge) begin
			mem[wrAddrA] <= merged;
		end
	end

	// (RULE2) drive requested data
	// (RULE3) one word per edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			dataOut_r <= '0;
			oe_r <= 1'b0;
			valid_r <= 1'b0;
			echo_r <= 1'b0;
		end else begin
			echo_r <= kPhase;
			// (RULE4) release when no read
			oe_r <= rdActive;
			// (RULE11) valid tracks driven data
			valid_r <= rdActive;
			if (rdActive) begin
				dataOut_r <= mem[rdWordAddr];
			end
		end
	end

	// (RULE5) one eighteen-bit word both ways
	assign dataOut = dataOut_r;
	assign dataOe = oe_r;
	assign output_valid_flag = valid_r;
	assign echo_clock = echo_r;
	assign echo_clock_n = !echo_r;

	// ============================================================
	// Write log occupancy, mirrors the FIFO handshakes
	wire logPush = wrEdge && fifoReady;
	wire logPop = wrLogValid && wrLogReady;

	always_comb begin
		logLevel_nxt = logLevel_r;
		if (logPush && !logPop) begin
			logLevel_nxt = logLevel_r + (`DBS_FIFO_PTR_W+1)'(1);
		end else if (logPop && !logPush) begin
			logLevel_nxt = logLevel_r - (`DBS_FIFO_PTR_W+1)'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			logLevel_r <= '0;
		end else begin
			logLevel_r <= logLevel_nxt;
		end
	end

	// ============================================================
	// Write log FIFO; bursts need room for both words
	dbsram_fifo #(
		.WIDTH(`DBS_DATA_W),
		.DEPTH(`DBS_FIFO_DEPTH),
		.PTR_W(`DBS_FIFO_PTR_W)
	) u_fifo (
		.mclk(mclk),
		.srst(srst),
		.inValid(wrEdge),
		.inReady(fifoReady),
		.inData(merged),
		.outValid(wrLogValid),
		.outReady(wrLogReady),
		.outData(wrLogData)
	);
endmodule // dbsram_port

// [sim/dbsram_port_sva.sv]
/* Pin assertions for the SRAM data port.
   Assumes binding into dbsram_port, one clock domain. */
module dbsram_port_sva (
	input wire logic mclk,
	input wire logic srst,
	input wire logic kPhase,
	input wire logic load_strobe_n,
	input wire logic readSel,
	input wire logic dataOe,
	input wire logic output_valid_flag,
	input wire logic echo_clock,
	input wire logic echo_clock_n,
	input wire logic wrLogValid,
	input wire logic wrLogReady,
	input wire logic cmdStall
);
	timeunit 1ns;
	timeprecision 100ps;
	// ========
	// Strobes count only in the positive phase
	wire logic rdGo = kPhase && !load_strobe_n && readSel;
	wire logic wrGo = kPhase && !load_strobe_n && !readSel;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_vld; output_valid_flag == dataOe; endproperty
	a_vld: assert property (p_vld) else $error("flag differs");
	property p_len; $rose(dataOe) |=> dataOe ##1 !dataOe; endproperty
	a_len: assert property (p_len) else $error("burst length");
	property p_lat; rdGo |-> ##[4:6] dataOe; endproperty
	a_lat: assert property (p_lat) else $error("no read data");
	property p_rel; $rose(dataOe) |-> $past(rdGo, 4) || $past(rdGo, 5)
		|| $past(rdGo, 6); endproperty
	a_rel: assert property (p_rel) else $error("drive w/o read");
	property p_eck; echo_clock == $past(kPhase)
		&& echo_clock_n == !echo_clock; endproperty
	a_eck: assert property (p_eck) else $error("echo clock");
	property p_stl; cmdStall |-> wrGo; endproperty
	a_stl: assert property (p_stl) else $error("odd stall");
	property p_log; wrGo && !cmdStall |-> ##[1:2] wrLogValid; endproperty
	a_log: assert property (p_log) else $error("write lost");
	property p_hld; wrLogValid && !wrLogReady |=> wrLogValid; endproperty
	a_hld: assert property (p_hld) else $error("log dropped");
endmodule // dbsram_port_sva

// [sim/dbsram_ctl_model.sv]
/* Controller side: alternates the edge phase, drains the write log.
   Assumes the bench drives strobe, address and data itself. */
module dbsram_ctl_model (
	input wire logic mclk,
	input wire logic srst,
	input wire logic hold,
	output logic kPhase = 1'h0,
	output logic wrLogReady = 1'h1
);
	timeunit 1ns;
	timeprecision 100ps;
	always @(negedge mclk) begin
		kPhase <= !srst && !kPhase;
		wrLogReady <= !hold;
	end
endmodule // dbsram_ctl_model

// [sim/testbench.sv]
/* Bench: table of bursts, then stall, odd-edge and reset cases.
   Assumes the controller model and the checker beside it. */
`include "dbsram_map.svh"
module testbench
	import dbsram_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic rd;
		dbsram_addr_t a;
		dbsram_word_t d0, d1;
		logic [1:0] b0, b1;
	} dbsram_row_s;
	logic mclk = 0;
	logic srst = 1;
	logic hold = 0;
	logic load_strobe_n = 1;
	logic readSel = 0;
	dbsram_addr_t addr = '0;
	logic [DBS_NBYTE-1:0] byte_write_select_n = '1;
	dbsram_word_t dataIn = '0;
	dbsram_word_t dataOut, wrLogData;
	logic kPhase, wrLogReady, dataOe, output_valid_flag, echo_clock;
	logic echo_clock_n, wrLogValid, cmdStall, lastStall;
	int err_total = 0;
	int compares = 0;
	int n;
	// Read rows hold the words the read must return
	dbsram_row_s rows [6] = '{
		'{1'h0, 8'h10, 18'h12345, 18'h2ABCD, 2'h0, 2'h0},
		'{1'h0, 8'hFE, 18'h0AAAA, 18'h35555, 2'h0, 2'h0},
		'{1'h1, 8'h10, 18'h12345, 18'h2ABCD, 2'h3, 2'h3},
		'{1'h0, 8'h11, 18'h3FFFF, 18'h00000, 2'h1, 2'h2},
		'{1'h1, 8'h11, 18'h3FF45, 18'h2AA00, 2'h3, 2'h3},
		'{1'h1, 8'hFF, 18'h0AAAA, 18'h35555, 2'h3, 2'h3}
	};
	dbsram_ctl_model ctl (.mclk, .srst, .hold, .kPhase, .wrLogReady);
	dbsram_port dut (.mclk, .srst, .kPhase, .load_strobe_n, .readSel, .addr,
		.byte_write_select_n, .dataIn, .dataOut, .dataOe, .output_valid_flag,
		.echo_clock, .echo_clock_n, .wrLogValid, .wrLogReady, .wrLogData,
		.cmdStall);
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input dbsram_word_t got, exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic burst(input logic rd, input dbsram_addr_t a,
		input dbsram_word_t d0, d1, input logic [1:0] b0, b1);
		@(negedge mclk);
		while (kPhase !== 1'b0)
			@(negedge mclk);
		load_strobe_n <= 0;
		readSel <= rd;
		addr <= a;
		dataIn <= d0;
		byte_write_select_n <= b0;
		#1 lastStall = cmdStall;
		@(negedge mclk);
		load_strobe_n <= 1;
		dataIn <= d1;
		byte_write_select_n <= b1;
	endtask
	task automatic rdchk(input dbsram_addr_t a, input dbsram_word_t e0, e1);
		burst(1'h1, a, '0, '0, 2'h3, 2'h3);
		n = 0;
		while (dataOe !== 1'b1 && n < 10) begin
			@(negedge mclk);
			n++;
		end
		chk(18'(dataOe), 18'h1);
		chk(dataOut, e0);
		@(negedge mclk);
		chk(dataOut, e1);
		@(negedge mclk);
		chk(18'(dataOe), 18'h0);
	endtask
	// Expected run is some 150 cycles; allow over ten times that
	initial begin
		#60us;
		err_total++;
		stop_test;
	end
	initial begin
		repeat (2) @(negedge mclk);
		srst <= 0;
		foreach (rows[i]) begin
			if (rows[i].rd)
				rdchk(rows[i].a, rows[i].d0, rows[i].d1);
			else
				burst(1'h0, rows[i].a, rows[i].d0, rows[i].d1,
					rows[i].b0, rows[i].b1);
		end
		$display("table done");
		hold <= 1;
		for (int i = 0; i < 17; i++) begin
			burst(1'h0, 8'(i < 16 ? 64 + 2 * i : 16), 18'(i), '0,
				2'h0, 2'h0);
			chk(18'(lastStall), 18'(i == 16));
		end
		rdchk(8'h10, 18'h3FF45, 18'h2AA00);
		hold <= 0;
		n = 0;
		repeat (40) begin
			@(posedge mclk);
			if (wrLogValid === 1'b1 && wrLogReady === 1'b1) begin
				chk(wrLogData, 18'(n[0] ? 0 : n / 2));
				n++;
			end
		end
		chk(18'(n), 18'h20);
		$display("stall done");
		@(negedge mclk);
		while (kPhase !== 1'b1)
			@(negedge mclk);
		// Strobe in the negative phase must be ignored
		load_strobe_n <= 0;
		readSel <= 1;
		@(negedge mclk);
		load_strobe_n <= 1;
		n = 0;
		repeat (10) begin
			@(negedge mclk);
			n += int'(dataOe !== 1'b0);
		end
		chk(18'(n), 18'h0);
		$display("odd edge done");
		burst(1'h1, 8'hFE, '0, '0, 2'h3, 2'h3);
		srst <= 1;
		repeat (2) @(negedge mclk);
		chk({dataOut | 18'({dataOe, output_valid_flag, wrLogValid, echo_clock})},
			18'h0);
		srst <= 0;
		rdchk(8'hFE, 18'h0AAAA, 18'h35555);
		$display("reset done");
		stop_test;
	end
endmodule // testbench
bind dbsram_port dbsram_port_sva sva (.mclk, .srst, .kPhase, .load_strobe_n,
	.readSel, .dataOe, .output_valid_flag, .echo_clock, .echo_clock_n,
	.wrLogValid, .wrLogReady, .cmdStall);
